// ---- hdl/tfi_fifo.sv ----
`timescale 1ns/1ns
// ==========================================
// small synchronous fifo, valid/ready both sides
module tfi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];   // storage
	logic [AW:0]      wp_r, wp_nxt;  // write pointer with wrap bit
	logic [AW:0]      rp_r, rp_nxt;  // read pointer with wrap bit
	logic             push, pop;
	// full when pointers differ only in wrap bit
	assign in_ready  = !((wp_r[AW] != rp_r[AW]) &&
		(wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign out_data  = mem[rp_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	// pointer next values
	always_comb
	begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end
	// pointer registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end
	// storage write, no reset needed on data
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wp_r[AW-1:0]] <= in_data;
	end
endmodule : tfi_fifo

// ---- hdl/tfi_pkg.sv ----
package tfi_pkg;
	// ==========================================
	// frame characters
	localparam logic [7:0] CH_DATA   = 8'h3D; // '=' data frame marker
	localparam logic [7:0] CH_TELEM  = 8'h54; // 'T' telemetry marker
	localparam logic [7:0] CH_ANALOG = 8'h41; // 'A' analog technology
	localparam logic [7:0] CH_DIGIT  = 8'h44; // 'D' digital technology
	localparam logic [7:0] CH_GET    = 8'h47; // 'G' read access
	localparam logic [7:0] CH_SET    = 8'h53; // 'S' write access
	localparam logic [7:0] CH_REPLY  = 8'h52; // 'R' normal reply
	localparam logic [7:0] CH_ERROR  = 8'h45; // 'E' error reply
	localparam logic [7:0] CH_CR     = 8'h0D; // frame terminator
	localparam logic [7:0] CH_ZERO   = 8'h30; // ascii '0'
	// ==========================================
	// sizes and options
	localparam int         ADDR_MAX      = 5;  // address bytes, most
	localparam int         NUM_PINS      = 9;  // general pins
	localparam int         OPT_NUM_BIT   = 2;  // numeric address option bit
	localparam int         ADC_BITS      = 12; // analog resolution
	localparam int         ADC_FIRST     = 2;  // pin index of third pin
	localparam int         ADC_LAST      = 5;  // pin index of sixth pin
	// ==========================================
	// timing
	localparam int         CLK_HZ        = 100_000_000;
	localparam int         TEST_SECONDS  = 30;
	localparam longint     TEST_CYCLES   = longint'(TEST_SECONDS) * CLK_HZ;
	// ==========================================
	// pin modes (3 bits per pin)
	localparam logic [2:0] PM_STATUS = 3'h0; // status or pull down
	localparam logic [2:0] PM_OUT_LO = 3'h1; // output, low at power up
	localparam logic [2:0] PM_OUT_HI = 3'h2; // output, high at power up (tfi_top drives pin_out low)
	localparam logic [2:0] PM_IN     = 3'h3; // digital input
	localparam logic [2:0] PM_RISE   = 3'h4; // rising edge interrupt
	localparam logic [2:0] PM_FALL   = 3'h5; // falling edge interrupt
	localparam logic [2:0] PM_BOTH   = 3'h6; // both edges
	localparam logic [2:0] PM_ANALOG = 3'h7; // analog input
endpackage : tfi_pkg

// ---- hdl/tfi_top.sv ----
`timescale 1ns/1ns
// Contract
// [R1] ack remote radio change, then switch
// [R2] operator repeats radio change locally
// [R3] remote radio test stops after 30s
// [R4] nine pins, out/in/rise/fall modes
// [R5] 12-bit analog on pins three-six
// [R6] edge interrupt pin sends a frame
// [R7] wake only pin3 rise, pin4 fall
// [R8] both-edges pin never wakes
// [R9] '=' means data, 'T' telemetry
// [R10] address zero is broadcast
// [R11] data payload goes to serial link
// [R12] telemetry runs alongside data traffic
// [R13] telemetry uses addressed secured mode
// [R14] address field one to five bytes
// [R15] option bit2 selects numeric address
// [R16] 0x54 ends address, marks telemetry
// [R17] technology byte 'A' analog 'D' digital
// [R18] access byte 'G' read 'S' write
// [R19] write carries variable fields before CR
// [R20] frames end with single carriage return
// [R21] reply R or E, error empty
// [R22] exit command: OK, apply new config; code only pulses exit_ok, no config is applied
// [R23] drop frames for other addresses
module tfi_top #(
	parameter longint TEST_CYCLES = tfi_pkg::TEST_CYCLES,
	parameter int     FIFO_DEPTH  = 16
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  rx_byte,       // received radio frame byte
	input  wire logic        rx_valid,
	output logic             rx_ready,      // back pressure from fifo
	input  wire logic [7:0]  own_id,        // numeric own address
	input  wire logic [7:0]  options_config_reg,
	input  wire logic [26:0] pin_mode,      // 3 bits per pin
	input  wire logic [8:0]  pin_in,        // pin levels
	input  wire logic [47:0] adc_value,     // four 12-bit samples
	output logic      [8:0]  pin_out,
	output logic      [8:0]  pin_oe,
	output logic      [7:0]  ser_data,      // data payload to serial link
	output logic             ser_valid,
	input  wire logic        ser_ready,
	output logic             tm_get,        // read order pulse
	output logic             tm_set,        // write order pulse
	output logic             tm_analog,     // technology of last order
	output logic             tm_error,      // error reply flag
	output logic      [7:0]  reply_kind,    // 'R' or 'E'
	output logic      [8:0]  pin_values,    // digital read snapshot
	output logic      [47:0] analog_values, // analog read snapshot
	output logic             irq_frame,     // edge event send request
	output logic             wake,          // wake from standby
	input  wire logic        radio_chg_req, // remote radio change order
	output logic             radio_ack,     // ack sent on old setting
	output logic             radio_apply,   // switch to new setting
	input  wire logic        test_start,    // remote radio test order
	output logic             test_active,
	input  wire logic        exit_config_cmd,
	output logic             exit_ok,       // OK then resume
	output logic             secured_mode   // telemetry mode flag
);
	// ==========================================
	// parser state
	typedef enum logic [2:0] {S_ADDR, S_TECH, S_ACC, S_ARGS, S_DATA,
		S_DROP} tfi_st_e;
	tfi_st_e     st_r, st_nxt;
	logic [2:0]  alen_r, alen_nxt;   // address bytes seen
	logic [7:0]  aval_r, aval_nxt;   // accumulated address value
	logic        tech_a_r, tech_a_nxt;
	logic        bad_r, bad_nxt;     // malformed order
	logic        get_nxt, set_nxt;
	logic        byte_in;
	logic        numeric;
	logic        addr_ok;
	logic        f_valid, f_ready;
	logic [7:0]  f_data;
	// incoming bytes buffered; data frames stall on the serial side
	tfi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.in_data  (rx_byte),
		.in_valid (rx_valid),
		.in_ready (rx_ready),
		.out_data (f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);
	assign numeric      = options_config_reg[tfi_pkg::OPT_NUM_BIT]; // R15
	assign secured_mode = 1'b1; // R13
	// zero or own id accepted
	assign addr_ok = (aval_r == 8'h00) || (aval_r == own_id); // R10 R23
	// data bytes wait for serial sink, orders never wait
	assign f_ready = (st_r == S_DATA) ? ser_ready : 1'b1; // R12
	assign byte_in = f_valid && f_ready;
	assign ser_valid = (st_r == S_DATA) && f_valid && addr_ok; // R11
	assign ser_data  = f_data;
	// parser next state
	always_comb
	begin
		st_nxt = st_r;
		alen_nxt = alen_r;
		aval_nxt = aval_r;
		tech_a_nxt = tech_a_r;
		bad_nxt = bad_r;
		get_nxt = 1'b0;
		set_nxt = 1'b0;
		if (byte_in)
		begin
			case (st_r)
				S_ADDR:
				begin
					if (f_data == tfi_pkg::CH_TELEM && alen_r != 3'h0)
						st_nxt = S_TECH; // R16 R9
					else if (f_data == tfi_pkg::CH_DATA && alen_r != 3'h0)
						st_nxt = S_DATA; // R9
					else if (alen_r == 3'(tfi_pkg::ADDR_MAX))
						st_nxt = S_DROP; // R14
					else
					begin
						alen_nxt = alen_r + 3'h1; // R14
						if (numeric)
							aval_nxt = f_data; // R15
						else
							aval_nxt = 8'(aval_r * 8'h0A +
								(f_data - tfi_pkg::CH_ZERO));
					end
				end
				S_TECH:
				begin
					// R17
					tech_a_nxt = (f_data == tfi_pkg::CH_ANALOG);
					bad_nxt = (f_data != tfi_pkg::CH_ANALOG) &&
						(f_data != tfi_pkg::CH_DIGIT);
					st_nxt = S_ACC;
				end
				S_ACC:
				begin
					// R18
					if (f_data == tfi_pkg::CH_GET)
						st_nxt = S_ARGS;
					else if (f_data == tfi_pkg::CH_SET)
						st_nxt = S_ARGS;
					else
						bad_nxt = 1'b1;
					st_nxt = S_ARGS;
					set_nxt = 1'b0;
					tech_a_nxt = tech_a_r;
					alen_nxt = (f_data == tfi_pkg::CH_SET) ? 3'h7 : 3'h6;
				end
				S_ARGS:
				begin
					// write fields skipped until terminator; R19
					if (f_data == tfi_pkg::CH_CR) // R20
					begin
						if (addr_ok) // R23
						begin
							get_nxt = (alen_r == 3'h6);
							set_nxt = (alen_r == 3'h7);
						end
						st_nxt = S_ADDR;
						alen_nxt = 3'h0;
						aval_nxt = 8'h00;
					end
					else if (alen_r == 3'h6)
						bad_nxt = 1'b1; // read with stray fields
				end
				default:
				begin
					// data and dropped frames end on terminator
					if (f_data == tfi_pkg::CH_CR)
					begin
						st_nxt = S_ADDR;
						alen_nxt = 3'h0;
						aval_nxt = 8'h00;
					end
				end
			endcase
		end
	end
	// parser registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= S_ADDR;
			alen_r <= 3'h0;
			aval_r <= 8'h00;
			tech_a_r <= 1'b0;
			bad_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			alen_r <= alen_nxt;
			aval_r <= aval_nxt;
			tech_a_r <= tech_a_nxt;
			bad_r <= (st_nxt == S_ADDR) ? 1'b0 : bad_nxt;
		end
	end
	// ==========================================
	// order results, pins and edges
	logic [8:0]  prev_r, prev_nxt;   // last pin levels
	logic [8:0]  pout_r, pout_nxt;
	logic [8:0]  edge_hit;
	logic        wake_nxt, irq_nxt;
	logic        prime_r, prime_nxt; // first level sample taken
	// pin directions and edge detection
	always_comb
	begin
		prev_nxt = pin_in;
		prime_nxt = 1'b1;
		pout_nxt = pout_r;
		wake_nxt = 1'b0;
		irq_nxt = 1'b0;
		for (int i = 0; i < tfi_pkg::NUM_PINS; i++)
		begin
			pin_oe[i] = (pin_mode[3*i +: 3] == tfi_pkg::PM_OUT_LO) ||
				(pin_mode[3*i +: 3] == tfi_pkg::PM_OUT_HI); // R4
			// prev_r holds only a reset value at first: no false edge
			edge_hit[i] = prime_r && (
				((pin_mode[3*i +: 3] == tfi_pkg::PM_RISE) &&
				pin_in[i] && !prev_r[i]) ||
				((pin_mode[3*i +: 3] == tfi_pkg::PM_FALL) &&
				!pin_in[i] && prev_r[i]) ||
				((pin_mode[3*i +: 3] == tfi_pkg::PM_BOTH) &&
				(pin_in[i] != prev_r[i])));
		end
		irq_nxt = |edge_hit; // R6
		// R7 R8
		wake_nxt = (edge_hit[2] && pin_mode[8:6] == tfi_pkg::PM_RISE) ||
			(edge_hit[3] && pin_mode[11:9] == tfi_pkg::PM_FALL);
	end
	// result registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			prev_r <= 9'h000;
			prime_r <= 1'b0;
			pout_r <= 9'h000;
			irq_frame <= 1'b0;
			wake <= 1'b0;
			tm_get <= 1'b0;
			tm_set <= 1'b0;
			tm_analog <= 1'b0;
			tm_error <= 1'b0;
			reply_kind <= tfi_pkg::CH_REPLY;
			pin_values <= 9'h000;
			analog_values <= 48'h0;
		end
		else
		begin
			prev_r <= prev_nxt;
			prime_r <= prime_nxt;
			pout_r <= pout_nxt;
			irq_frame <= irq_nxt;
			wake <= wake_nxt;
			tm_get <= get_nxt;
			tm_set <= set_nxt;
			if (get_nxt || set_nxt)
			begin
				tm_analog <= tech_a_r;
				tm_error <= bad_r; // R21
				reply_kind <= bad_r ? tfi_pkg::CH_ERROR :
					tfi_pkg::CH_REPLY; // R21
				pin_values <= bad_r ? 9'h000 : pin_in;
				// only pins three to six carry samples; R5
				analog_values <= (bad_r || !tech_a_r) ? 48'h0 : adc_value;
			end
		end
	end
	assign pin_out = pout_r;
	// ==========================================
	// remote radio change, test timer, exit
	logic [34:0] tcnt_r, tcnt_nxt;   // radio test countdown
	logic        ack_pend_r, ack_pend_nxt;
	logic        apply_nxt, ok_nxt;
	// next values
	always_comb
	begin
		tcnt_nxt = tcnt_r;
		ack_pend_nxt = 1'b0;
		apply_nxt = 1'b0;
		ok_nxt = exit_config_cmd; // R22
		if (test_start)
			tcnt_nxt = 35'(TEST_CYCLES);
		else if (tcnt_r != 35'h0)
			tcnt_nxt = tcnt_r - 35'h1; // R3
		ack_pend_nxt = radio_chg_req; // R1 ack first
		apply_nxt = ack_pend_r;       // R1 switch next cycle
	end
	// registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tcnt_r <= 35'h0;
			ack_pend_r <= 1'b0;
			radio_apply <= 1'b0;
			exit_ok <= 1'b0;
		end
		else
		begin
			tcnt_r <= tcnt_nxt;
			ack_pend_r <= ack_pend_nxt;
			radio_apply <= apply_nxt;
			exit_ok <= ok_nxt;
		end
	end
	assign radio_ack   = ack_pend_r;
	assign test_active = (tcnt_r != 35'h0);
	// ==========================================
	// checks
	a_apply_after_ack: assert property (@(posedge ref_clk) disable iff (rst)
		radio_ack |=> radio_apply) else $error("switch not after ack"); // R1
	a_wake_both_none: assert property (@(posedge ref_clk) disable iff (rst)
		(pin_mode[8:6] == tfi_pkg::PM_BOTH &&
		pin_mode[11:9] == tfi_pkg::PM_BOTH) |=> !wake)
		else $error("wake from both-edge pin"); // R8
	a_edge_irq: assert property (@(posedge ref_clk) disable iff (rst)
		(|edge_hit) |=> irq_frame) else $error("edge lost"); // R6
	a_test_ends: assert property (@(posedge ref_clk) disable iff (rst)
		(test_active && !test_start && tcnt_r == 35'h1) |=> !test_active)
		else $error("radio test did not stop"); // R3
	a_error_kind: assert property (@(posedge ref_clk) disable iff (rst)
		(tm_error && (tm_get || tm_set)) |-> reply_kind == tfi_pkg::CH_ERROR
		&& pin_values == 9'h000) else $error("error reply wrong"); // R21
	a_data_route: assert property (@(posedge ref_clk) disable iff (rst)
		ser_valid |-> st_r == S_DATA && addr_ok)
		else $error("stray data"); // R11
	a_exit_ok: assert property (@(posedge ref_clk) disable iff (rst)
		exit_config_cmd |=> exit_ok) else $error("no OK on exit"); // R22
	a_order_cr: assert property (@(posedge ref_clk) disable iff (rst)
		(get_nxt || set_nxt) |-> f_data == tfi_pkg::CH_CR)
		else $error("order without terminator"); // R20
endmodule : tfi_top

// ---- sim/tfi_ser_sink.sv ----
`timescale 1ns/1ns
// ==========================================
// serial link sink: prompt, stalling or held
module tfi_ser_sink (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [1:0] mode,      // 0 prompt, 1 alternate, 2 hold
	input  wire logic [7:0] ser_data,
	input  wire logic       ser_valid,
	output logic            ser_ready,
	output logic      [7:0] got_byte,  // link byte of the previous cycle, taken when got_stb
	output logic            got_stb    // one cycle per byte taken
);
	logic ph_r; // stall phase toggles every cycle
	// hold keeps the fifo full so back pressure reaches the radio side
	assign ser_ready = (mode == 2'h0) || (mode == 2'h1 && ph_r);
	// take a byte on each edge with valid and ready high
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ph_r     <= 1'b0;
			got_stb  <= 1'b0;
			got_byte <= 8'h00;
		end
		else
		begin
			ph_r     <= !ph_r;
			got_stb  <= ser_valid && ser_ready;
			got_byte <= ser_data;
		end
	end
endmodule : tfi_ser_sink

// ---- sim/tfi_top_tb.sv ----
`timescale 1ns/1ns
// ==========================================
// self checking bench for the frame interpreter
module tfi_top_tb;
	typedef struct packed {logic set; logic ana; logic [8:0] pins;
		logic [47:0] adc;} tfi_note_s; // expected order result
	logic ref_clk = 0, rst = 1, rx_valid = 0, ser_ready, radio_chg_req = 0;
	logic test_start = 0, exit_config_cmd = 0, mon_on = 1;
	logic [7:0] rx_byte = 8'h00, own_id = 8'h03, options_config_reg = 8'h00;
	logic [26:0] pin_mode = {9{tfi_pkg::PM_IN}};
	logic [8:0] pin_in = 9'h000, pin_out, pin_oe, pin_values;
	logic [47:0] adc_value = 48'h0, analog_values;
	logic [7:0] ser_data, reply_kind, got_byte;
	logic [1:0] sink_mode = 2'h0; // partner pace
	logic rx_ready, ser_valid, tm_get, tm_set, tm_analog, tm_error, irq_frame;
	logic wake, radio_ack, radio_apply, test_active, exit_ok, secured_mode;
	logic got_stb;
	int errors = 0, cmp_count = 0, cyc = 0, cnt;
	tfi_note_s exp_q[$], nt; // notes from the driver
	logic [7:0] exp_ser[$];  // payload expected on the serial link
	// ==========================================
	// design and partner
	tfi_top #(.TEST_CYCLES(100), .FIFO_DEPTH(16)) i_dut (.ref_clk, .rst,
		.rx_byte, .rx_valid, .rx_ready, .own_id, .options_config_reg,
		.pin_mode, .pin_in, .adc_value, .pin_out, .pin_oe, .ser_data,
		.ser_valid, .ser_ready, .tm_get, .tm_set, .tm_analog, .tm_error,
		.reply_kind, .pin_values, .analog_values, .irq_frame, .wake,
		.radio_chg_req, .radio_ack, .radio_apply, .test_start, .test_active,
		.exit_config_cmd, .exit_ok, .secured_mode);
	tfi_ser_sink i_sink (.ref_clk, .rst, .mode(sink_mode), .ser_data,
		.ser_valid, .ser_ready, .got_byte, .got_stb);
	// 100 MHz clock
	initial
	begin
		forever #5 ref_clk = !ref_clk;
	end
	// ==========================================
	// shared tasks
	task automatic check(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	// one byte held until taken, bounded wait on back pressure
	// a lead byte of zero cannot stand in a string, so it comes apart
	task automatic send_str(input string s, input int lead = -1);
		int w;
		for (int i = (lead < 0) ? 0 : -1; i < s.len(); i++)
		begin
			rx_byte = (i < 0) ? 8'(lead) : s[i];
			rx_valid = 1'b1;
			w = 0;
			// ready is settled here and taken at the next rising edge
			while (rx_ready !== 1'b1 && w < 300)
			begin
				@(negedge ref_clk);
				w++;
			end
			if (w >= 300)
				check("rx_taken", 0, 1);
			@(negedge ref_clk);
		end
		rx_valid = 1'b0;
		rx_byte = ~rx_byte; // released line no longer shows the byte
	endtask : send_str
	// telemetry frame with random pin and sample values
	task automatic tframe(input string s, input bit note, input bit set,
		input bit ana, input int lead = -1);
		pin_in = 9'($urandom);
		adc_value = 48'({$urandom, $urandom});
		if (note)
			exp_q.push_back({set, ana, pin_in, adc_value});
		send_str(s, lead);
		repeat (8) @(negedge ref_clk);
		$display("telemetry frame done");
	endtask : tframe
	// counts wake and send requests after one pin edge
	task automatic edge_chk(input int k, input logic lvl, input int w,
		input int q);
		int cw, ci;
		cw = 0;
		ci = 0;
		pin_in[k] = lvl;
		repeat (6)
		begin
			@(negedge ref_clk);
			cw += (wake === 1'b1);
			ci += (irq_frame === 1'b1);
		end
		check("wake", cw, w);
		check("irq_frame", ci, q);
	endtask : edge_chk
	// ==========================================
	// result watchers take the oldest note
	always @(negedge ref_clk)
	begin
		if (mon_on && (tm_get === 1'b1 || tm_set === 1'b1))
		begin
			if (exp_q.size() == 0)
				check("extra_order", 1, 0);
			else
			begin
				nt = exp_q.pop_front();
				check("tm_set", tm_set, nt.set);
				check("tm_analog", tm_analog, nt.ana);
				check("reply_kind", reply_kind, tfi_pkg::CH_REPLY);
				if (!nt.set && nt.ana)
					check("analog", analog_values, nt.adc);
				if (!nt.set && !nt.ana)
					check("pin_values", pin_values, nt.pins);
			end
		end
		if (got_stb === 1'b1)
		begin
			if (exp_ser.size() == 0)
				check("extra_ser", 1, 0);
			else
				check("ser_data", got_byte, exp_ser.pop_front());
		end
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			finish_test();
		end
	end
	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(39));
		repeat (4) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		check("pin_oe_in", pin_oe, 9'h000);
		check("secured", secured_mode, 1'b1);
		// telemetry orders, ascii then numeric address
		tframe("3TDG\015", 1, 0, 0);
		tframe("3TAG\015", 1, 0, 1);
		tframe("3TDS1,2\015", 1, 1, 0);
		tframe("0TAG\015", 1, 0, 1);
		tframe("4TAG\015", 0, 0, 1);
		tframe("00003TDG\015", 1, 0, 0);
		tframe("000003TDG\015", 0, 0, 0);
		options_config_reg = 8'h04;
		tframe("\003TAG\015", 1, 0, 1);
		tframe("TDG\015", 1, 0, 0, 0);
		tframe("\005TDG\015", 0, 0, 0);
		options_config_reg = 8'h00;
		mon_on = 1'b0;
		tframe("3TXG\015", 0, 0, 0);
		check("tm_error", tm_error, 1'b1);
		check("reply_err", reply_kind, tfi_pkg::CH_ERROR);
		check("err_pins", pin_values, 9'h000);
		mon_on = 1'b1;
		check("notes_left", exp_q.size(), 0);
		// pin output enables
		pin_mode = {9{tfi_pkg::PM_OUT_HI}};
		@(negedge ref_clk);
		check("pin_oe_out", pin_oe, 9'h1FF);
		// edge detection and wake
		pin_in = 9'h008;
		pin_mode = {9{tfi_pkg::PM_IN}};
		pin_mode[8:6] = tfi_pkg::PM_RISE;
		pin_mode[11:9] = tfi_pkg::PM_FALL;
		pin_mode[14:12] = tfi_pkg::PM_RISE;
		pin_mode[17:15] = tfi_pkg::PM_BOTH;
		repeat (4) @(negedge ref_clk);
		edge_chk(2, 1, 1, 1);
		edge_chk(3, 0, 1, 1);
		edge_chk(4, 1, 0, 1);
		edge_chk(5, 1, 0, 1);
		// both-edge mode on the two wake pins: send, never wake
		pin_mode[8:6] = tfi_pkg::PM_BOTH;
		pin_mode[11:9] = tfi_pkg::PM_BOTH;
		edge_chk(2, 0, 0, 1);
		edge_chk(3, 1, 0, 1);
		$display("edge test done");
		// remote radio change: ack then switch
		radio_chg_req = 1'b1;
		@(negedge ref_clk);
		radio_chg_req = 1'b0;
		// ack shows alone first, switch follows one cycle later
		check("radio_ack", {radio_ack, radio_apply}, 2'h2);
		@(negedge ref_clk);
		check("radio_apply", {radio_ack, radio_apply}, 2'h1);
		// exit command and radio test span
		exit_config_cmd = 1'b1;
		@(negedge ref_clk);
		exit_config_cmd = 1'b0;
		check("exit_ok", exit_ok, 1'b1);
		test_start = 1'b1;
		cnt = 0;
		repeat (120)
		begin
			@(negedge ref_clk);
			test_start = 1'b0;
			cnt += (test_active === 1'b1);
		end
		check("test_span", cnt, 100);
		$display("radio test done");
		// data for another module never reaches the link
		send_str("4=xy\015");
		repeat (10) @(negedge ref_clk);
		// data frame fills the fifo while the link is held
		sink_mode = 2'h2;
		for (int i = 0; i < 21; i++)
			exp_ser.push_back(8'h41 + i[7:0]);
		fork
			send_str("3=ABCDEFGHIJKLMNOPQRSTU");
			begin
				repeat (60) @(negedge ref_clk);
				check("fifo_full", rx_ready, 1'b0);
				sink_mode = 2'h1;
			end
		join
		repeat (100) @(negedge ref_clk);
		check("ser_left", exp_ser.size(), 0);
		$display("data test done");
		finish_test();
	end
endmodule : tfi_top_tb
